// ==== verilog/lbpc_ladder_ctrl.sv ====
// The implementer's own choices: the register offsets and strobed register access.
`include "lbpc_defs.svh"
module lbpc_ladder_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_tick_32k,
  input wire logic i_seg_transition,
  input wire logic [3:0] i_pin_direction_bits,
  output logic [7:0] o_rdata,
  output logic [1:0] o_ladder_power,
  output logic o_ladder_connect,
  output logic o_half_bias_short,
  output logic o_interval_a,
  output logic [6:0] o_contrast_tap,
  output logic o_ref_io_supply_en,
  output logic o_ref_fixed_buf_en,
  output logic o_fixed_voltage_ref_req,
  output logic [2:0] o_external_bias_pins_en,
  output logic [3:0] o_common_active,
  output logic [3:0] o_pin_oe_n,
  output logic o_phase_per_slice
);

  logic [7:0] ladder_reg;
  logic [7:0] main_reg;
  logic [7:0] ref_reg;
  logic [7:0] contrast_reg;
  logic [`LBPC_PRESC_W-1:0] presc_reg;
  lbpc_pkg::lbpc_phase_t phase_reg;
  logic [1:0] power_next;
  logic [6:0] tap_next;
  logic [3:0] com_next;
  logic [7:0] rdata_next;

  function automatic logic [3:0] lbpc_com_decode(input logic [1:0] sel);
    case (sel)
      `LBPC_MUX_STATIC: begin
        lbpc_com_decode = `LBPC_COM_STATIC;
      end
      `LBPC_MUX_HALF: begin
        lbpc_com_decode = `LBPC_COM_HALF;
      end
      `LBPC_MUX_THIRD: begin
        lbpc_com_decode = `LBPC_COM_THIRD;
      end
      default: begin
        lbpc_com_decode = `LBPC_COM_ALL;
      end
    endcase
  endfunction

  function automatic logic [`LBPC_PRESC_W-1:0] lbpc_presc_inc(input logic [`LBPC_PRESC_W-1:0] cnt);
    lbpc_presc_inc = cnt + `LBPC_PRESC_STEP;
  endfunction

  wire logic active = main_reg[`LBPC_MAIN_ACTIVE];
  wire logic [2:0] a_interval_length = ladder_reg[`LBPC_A_LEN_HI:`LBPC_A_LEN_LO];
  wire logic [`LBPC_PRESC_W-1:0] period_end =
    main_reg[`LBPC_MAIN_WFT] ? `LBPC_PERIOD_TYPE_B : `LBPC_PERIOD_TYPE_A;
  wire logic ref_en = ref_reg[`LBPC_REF_EN] & active;
  wire logic in_a = (phase_reg == lbpc_pkg::LBPC_ST_A);
  wire logic a_len_zero = (a_interval_length == `LBPC_ZERO_LEN);
  wire logic [`LBPC_PRESC_W-1:0] a_len_wide = {`LBPC_LEN_PAD, a_interval_length};
  wire logic period_wrap = (presc_reg == period_end);
  wire logic a_done = (lbpc_presc_inc(presc_reg) >= a_len_wide);
  wire logic [2:0] contrast_sel = contrast_reg[`LBPC_CONTRAST_HI:`LBPC_CONTRAST_LO];
  wire logic [1:0] power_a_sel = ladder_reg[`LBPC_A_PWR_HI:`LBPC_A_PWR_LO];
  wire logic [1:0] power_b_sel = ladder_reg[`LBPC_B_PWR_HI:`LBPC_B_PWR_LO];
  wire logic ladder_on_next = (power_next != lbpc_pkg::LBPC_PWR_OFF);
  wire logic half_sel = main_reg[`LBPC_MAIN_HALF];
  wire logic wft_sel = main_reg[`LBPC_MAIN_WFT];
  wire logic fvr_sel = ref_en & ref_reg[`LBPC_REF_FVR];
  wire logic buf_idle = ref_reg[`LBPC_REF_IDLE] & ~in_a;
  wire logic [7:0] status_byte = {`LBPC_STATUS_PAD, in_a, o_ladder_power};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ladder_reg <= `LBPC_RESET_BYTE;
    end else if (i_wr && i_addr == `LBPC_ADDR_LADDER) begin
      ladder_reg <= i_wdata & `LBPC_LADDER_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      main_reg <= `LBPC_RESET_BYTE;
    end else if (i_wr && i_addr == `LBPC_ADDR_MAIN) begin
      main_reg <= i_wdata & `LBPC_MAIN_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ref_reg <= `LBPC_RESET_BYTE;
    end else if (i_wr && i_addr == `LBPC_ADDR_REF) begin
      ref_reg <= i_wdata & `LBPC_REF_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      contrast_reg <= `LBPC_RESET_BYTE;
    end else if (i_wr && i_addr == `LBPC_ADDR_CONTRAST) begin
      contrast_reg <= i_wdata & `LBPC_CONTRAST_MASK;
    end
  end

  // register read mux
  always_comb begin
    case (i_addr)
      `LBPC_ADDR_LADDER: begin
        rdata_next = ladder_reg;
      end
      `LBPC_ADDR_MAIN: begin
        rdata_next = main_reg;
      end
      `LBPC_ADDR_REF: begin
        rdata_next = ref_reg;
      end
      `LBPC_ADDR_CONTRAST: begin
        rdata_next = contrast_reg;
      end
      `LBPC_ADDR_STATUS: begin
        rdata_next = status_byte;
      end
      default: begin
        rdata_next = `LBPC_RESET_BYTE;
      end
    endcase
  end

  // read data stands one cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= `LBPC_RESET_BYTE;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= `LBPC_RESET_BYTE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      presc_reg <= '0;
    end else if (!active) begin
      presc_reg <= '0;
    end else if (i_seg_transition) begin
      presc_reg <= '0;
    end else if (i_tick_32k) begin
      presc_reg <= period_wrap ? '0 : lbpc_presc_inc(presc_reg);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      phase_reg <= lbpc_pkg::LBPC_ST_IDLE;
    end else if (!active) begin
      phase_reg <= lbpc_pkg::LBPC_ST_IDLE;
    end else if (i_seg_transition) begin
      phase_reg <= a_len_zero ? lbpc_pkg::LBPC_ST_B : lbpc_pkg::LBPC_ST_A;
    end else if (i_tick_32k) begin
      case (phase_reg)
        lbpc_pkg::LBPC_ST_IDLE: begin
          phase_reg <= lbpc_pkg::LBPC_ST_B;
        end
        lbpc_pkg::LBPC_ST_A: begin
          if (a_done) begin
            phase_reg <= lbpc_pkg::LBPC_ST_B;
          end
        end
        lbpc_pkg::LBPC_ST_B: begin
          if (period_wrap && !a_len_zero) begin
            phase_reg <= lbpc_pkg::LBPC_ST_A;
          end
        end
        default: begin
          phase_reg <= lbpc_pkg::LBPC_ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    case (phase_reg)
      lbpc_pkg::LBPC_ST_A: begin
        power_next = power_a_sel;
      end
      lbpc_pkg::LBPC_ST_B: begin
        power_next = power_b_sel;
      end
      default: begin
        power_next = lbpc_pkg::LBPC_PWR_OFF;
      end
    endcase
    if (!active) begin
      power_next = lbpc_pkg::LBPC_PWR_OFF;
    end
  end

  always_comb begin
    tap_next = `LBPC_TAP_NONE;
    if (contrast_sel != `LBPC_CONTRAST_SHORT) begin
      tap_next[contrast_sel - `LBPC_TAP_BASE] = 1'b1;
    end
    if (!ref_en) begin
      tap_next = `LBPC_TAP_NONE;
    end
  end

  always_comb begin
    if (active) begin
      com_next = lbpc_com_decode(main_reg[`LBPC_MAIN_MUX_HI:`LBPC_MAIN_MUX_LO]);
    end else begin
      com_next = `LBPC_COM_NONE;
    end
  end

  // ladder power output
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ladder_power <= lbpc_pkg::LBPC_PWR_OFF;
    end else begin
      o_ladder_power <= power_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ladder_connect <= 1'b0;
    end else begin
      o_ladder_connect <= ladder_on_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_half_bias_short <= 1'b0;
    end else begin
      o_half_bias_short <= half_sel & ladder_on_next;
    end
  end

  // interval A indication
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_interval_a <= 1'b0;
    end else begin
      o_interval_a <= in_a & active;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_phase_per_slice <= 1'b0;
    end else begin
      o_phase_per_slice <= ~wft_sel;
    end
  end

  // contrast tap output
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_contrast_tap <= `LBPC_TAP_NONE;
    end else begin
      o_contrast_tap <= tap_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ref_io_supply_en <= 1'b0;
    end else begin
      o_ref_io_supply_en <= ref_en & ~ref_reg[`LBPC_REF_FVR];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ref_fixed_buf_en <= 1'b0;
    end else begin
      o_ref_fixed_buf_en <= fvr_sel & ~buf_idle;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_fixed_voltage_ref_req <= 1'b0;
    end else begin
      o_fixed_voltage_ref_req <= fvr_sel;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_external_bias_pins_en <= '0;
    end else begin
      o_external_bias_pins_en <= ref_reg[`LBPC_REF_PIN_HI:`LBPC_REF_PIN_LO];
    end
  end

  // active commons output
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_common_active <= `LBPC_COM_NONE;
    end else begin
      o_common_active <= com_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pin_oe_n <= `LBPC_PIN_OE_IDLE;
    end else begin
      o_pin_oe_n <= ~com_next & i_pin_direction_bits;
    end
  end

endmodule

// ==== verilog/lbpc_defs.svh ====
`ifndef LBPC_DEFS_SVH
`define LBPC_DEFS_SVH
// register offsets
`define LBPC_ADDR_LADDER 4'h0
`define LBPC_ADDR_MAIN 4'h1
`define LBPC_ADDR_REF 4'h2
`define LBPC_ADDR_CONTRAST 4'h3
`define LBPC_ADDR_STATUS 4'h4
// ladder_power_switch_control fields
`define LBPC_A_PWR_HI 7
`define LBPC_A_PWR_LO 6
`define LBPC_B_PWR_HI 5
`define LBPC_B_PWR_LO 4
`define LBPC_A_LEN_HI 2
`define LBPC_A_LEN_LO 0
`define LBPC_LADDER_MASK 8'hF7
// display_main_control fields
`define LBPC_MAIN_ACTIVE 7
`define LBPC_MAIN_WFT 6
`define LBPC_MAIN_HALF 5
`define LBPC_MAIN_MUX_HI 1
`define LBPC_MAIN_MUX_LO 0
`define LBPC_MAIN_MASK 8'hE3
// bias_reference_control fields, then the contrast register mask
`define LBPC_REF_EN 7
`define LBPC_REF_FVR 6
`define LBPC_REF_IDLE 5
`define LBPC_REF_PIN_HI 3
`define LBPC_REF_PIN_LO 1
`define LBPC_REF_MASK 8'hEE
`define LBPC_CONTRAST_MASK 8'h07
// timing: 32 kHz tick prescaler, periods per waveform type
`define LBPC_PRESC_W 5
`define LBPC_PERIOD_TYPE_A 5'h0F
`define LBPC_PERIOD_TYPE_B 5'h1F
`define LBPC_RESET_BYTE 8'h00
`define LBPC_ZERO_LEN 3'h0
`define LBPC_PRESC_STEP 5'h01
`define LBPC_LEN_PAD 2'h0
`define LBPC_STATUS_PAD 5'h00
// contrast decode
`define LBPC_CONTRAST_HI 2
`define LBPC_CONTRAST_LO 0
`define LBPC_CONTRAST_SHORT 3'h0
`define LBPC_TAP_BASE 3'h1
`define LBPC_TAP_NONE 7'h00
// multiplex decode
`define LBPC_MUX_STATIC 2'h0
`define LBPC_MUX_HALF 2'h1
`define LBPC_MUX_THIRD 2'h2
`define LBPC_COM_NONE 4'h0
`define LBPC_COM_STATIC 4'h1
`define LBPC_COM_HALF 4'h3
`define LBPC_COM_THIRD 4'h7
`define LBPC_COM_ALL 4'hF
`define LBPC_PIN_OE_IDLE 4'hF
`endif

// ==== verilog/lbpc_pkg.sv ====
package lbpc_pkg;
  typedef enum logic [1:0] {
    LBPC_PWR_OFF,
    LBPC_PWR_LOW,
    LBPC_PWR_MED,
    LBPC_PWR_HIGH
  } lbpc_power_t;
  typedef enum {
    LBPC_ST_IDLE,
    LBPC_ST_A,
    LBPC_ST_B
  } lbpc_phase_t;
endpackage

// ==== bench/lbpc_ladder_ctrl_properties.sv ====
module lbpc_ladder_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_ladder_power,
  input wire logic o_ladder_connect,
  input wire logic o_half_bias_short,
  input wire logic o_interval_a,
  input wire logic [6:0] o_contrast_tap,
  input wire logic o_ref_io_supply_en,
  input wire logic o_ref_fixed_buf_en,
  input wire logic o_fixed_voltage_ref_req,
  input wire logic [2:0] o_external_bias_pins_en,
  input wire logic [3:0] o_common_active,
  input wire logic [3:0] o_pin_oe_n,
  input wire logic o_phase_per_slice
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  bit3_zero_a: assert property ($past(i_rd) && $past(i_addr) == 4'h0 |-> !o_rdata[3])
    else $error("ladder control bit 3 read as one");
  taps_open_a: assert property (o_ladder_connect == (o_ladder_power != 2'h0))
    else $error("ladder taps disagree with power");
  half_short_a: assert property (o_half_bias_short |-> o_ladder_connect)
    else $error("half bias short with ladder off");
  com_override_a: assert property ((o_common_active & o_pin_oe_n) == 4'h0)
    else $error("active common not driving");
  com_set_a: assert property (o_common_active inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("common set not contiguous");
  tap_single_a: assert property ($onehot0(o_contrast_tap))
    else $error("more than one contrast tap");
  ref_source_a: assert property (!(o_ref_io_supply_en && o_ref_fixed_buf_en))
    else $error("two reference sources on");
  fvr_auto_a: assert property (o_ref_fixed_buf_en |-> o_fixed_voltage_ref_req)
    else $error("buffer on without fixed reference");
  wft_phase_a: assert property (i_wr && i_addr == 4'h1 ##1 !i_wr [*2] |-> o_phase_per_slice == !$past(i_wdata[6], 2))
    else $error("phase mode wrong after write");
  pin_en_a: assert property (i_wr && i_addr == 4'h2 ##1 !i_wr [*2] |-> o_external_bias_pins_en == $past(i_wdata[3:1], 2))
    else $error("bias pin enables wrong after write");
  cover property (o_interval_a);
  cover property (o_half_bias_short);
  cover property (o_contrast_tap == 7'h40);
endmodule
bind lbpc_ladder_ctrl lbpc_ladder_checker chk_u (.*);

// ==== bench/lbpc_ladder_ctrl_test.sv ====
module lbpc_ladder_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tick_32k = 1'b0, i_seg_transition = 1'b0;
  logic [3:0] i_addr = 4'h0, i_pin_direction_bits = 4'hA, o_common_active, o_pin_oe_n;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic [1:0] o_ladder_power;
  logic o_ladder_connect, o_half_bias_short, o_interval_a, o_ref_io_supply_en;
  logic o_ref_fixed_buf_en, o_fixed_voltage_ref_req, o_phase_per_slice;
  logic [6:0] o_contrast_tap;
  logic [2:0] o_external_bias_pins_en;
  int fails = 0, n_checks = 0;
  lbpc_ladder_ctrl dut_u (.*);
  initial forever #5 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic step(input logic t, input logic s);
    @(posedge i_clk_sys);
    i_tick_32k <= t;
    i_seg_transition <= s;
    @(posedge i_clk_sys);
    i_tick_32k <= 1'b0;
    i_seg_transition <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    give_verdict;
  end
  initial begin
    int p;
    logic ia;
    logic [7:0] m [4];
    m = '{8'hF7, 8'hE3, 8'hEE, 8'h07};
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rdc(4'(a), 8'h00);
    chk(8'(o_pin_oe_n), 8'h0A);
    wr(4'h8, 8'hFF);
    for (int a = 0; a < 4; a++) begin
      wr(4'(a), 8'hFF);
      rdc(4'(a), m[a]);
    end
    rdc(4'h8, 8'h00);
    wr(4'h1, 8'h63);
    chk(8'(o_ladder_power), 8'h00);
    chk(8'(o_contrast_tap), 8'h00);
    chk(8'({o_ref_io_supply_en, o_ref_fixed_buf_en}), 8'h00);
    $display("registers and inactive done");
    wr(4'h2, 8'hE0);
    for (int c = 0; c < 3; c++) begin
      p = (c == 1) ? 32 : 16;
      wr(4'h0, 8'hD0 | ((c == 0) ? 8'h03 : (c == 1) ? 8'h07 : 8'h00));
      wr(4'h1, (c == 1) ? 8'hE3 : 8'hA3);
      step(1'b0, 1'b1);
      chk(8'(o_half_bias_short), 8'h01);
      chk(8'(o_phase_per_slice), (c == 1) ? 8'h00 : 8'h01);
      chk(8'(o_fixed_voltage_ref_req), 8'h01);
      for (int k = 0; k <= p; k++) begin
        if (k > 0) step(1'b1, 1'b0);
        ia = (k % p) < ((c == 0) ? 3 : (c == 1) ? 7 : 0);
        chk(8'(o_ladder_power), ia ? 8'h03 : 8'h01);
        chk(8'(o_ref_fixed_buf_en), 8'(ia));
        chk(8'({o_interval_a, o_ladder_connect}), ia ? 8'h03 : 8'h01);
      end
    end
    $display("interval timing done");
    for (int c = 0; c < 8; c++) begin
      wr(4'h2, 8'(8'h80 | (c << 1)));
      wr(4'h3, 8'(c));
      chk(8'(o_contrast_tap), (c > 0) ? 8'(1 << (c - 1)) : 8'h00);
      chk(8'({o_ref_io_supply_en, o_external_bias_pins_en}), 8'(8 | c));
      chk(8'({o_fixed_voltage_ref_req, o_ref_fixed_buf_en}), 8'h00);
    end
    for (int n = 0; n < 4; n++) begin
      wr(4'h1, 8'(8'h80 | n));
      chk(8'(o_common_active), 8'((2 << n) - 1));
      chk(8'(o_pin_oe_n), 8'(~((2 << n) - 1) & 4'hA));
    end
    wr(4'h2, 8'h00);
    chk(8'(o_contrast_tap), 8'h00);
    $display("contrast and commons done");
    give_verdict;
  end
endmodule
